//--- pkg/frs_consts.vh
// constants for the fan reverse sequencer
`ifndef FRS_CONSTS_VH
`define FRS_CONSTS_VH
`define FRS_A_CTRL 4'h0
`define FRS_A_INCFG 4'h1
`define FRS_A_ERRLIM 4'h2
`define FRS_A_TEMPPT 4'h3
`define FRS_A_PROF 4'h4
`define FRS_A_STEPTM 4'h5
`define FRS_A_STEPI 4'h6
`define FRS_A_TRIG 4'h7
`define FRS_A_STAT 4'h8
`define FRS_A_OUT 4'h9
`define FRS_MODE_OFF 3'h0
`define FRS_MODE_OTC 3'h1
`define FRS_MODE_OTO 3'h2
`define FRS_MODE_NET 3'h3
`define FRS_MODE_PER 3'h4
`define FRS_IN_TSENS 3'h4
`define FRS_FULL_SCALE 16'hffff
`define FRS_OT_DEFAULT 16'h0091
`define FRS_PER_DEFAULT 16'h0708
`define FRS_PER_SHORT 16'h00b4
`define FRS_CLK_HZ 20000000
`define FRS_SEC_CYC (`FRS_CLK_HZ / 1)
`define FRS_BOOST_SEC 32'h1
`define FRS_MIN_SEC 60
`endif

//--- verilog/frs_top.v
// fan reverse sequencer: input scaling, fault check, reverse sequence
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "frs_consts.vh"
module frs_top (
   input wire clk_sys_in,
   input wire sys_rst_in,
   input wire [3:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [31:0] reg_rdata_out,
   input wire [15:0] ext_raw_in,
   input wire [15:0] net_value_in,
   output reg [15:0] coil_a_ma_out,
   output reg [15:0] coil_b_ma_out,
   output reg bias_pullup_out,
   output reg bias_pulldown_out,
   output reg err_msg_out,
   output reg fault_out,
   output reg seq_active_out
);
   parameter SEC_CYC = `FRS_SEC_CYC;
   localparam ST_IDLE = 7'h01;
   localparam ST_STOPF = 7'h02;
   localparam ST_BOOST = 7'h04;
   localparam ST_REV = 7'h08;
   localparam ST_STOPR = 7'h10;
   localparam ST_BURST = 7'h20;
   localparam ST_LOCK = 7'h40;

   reg [2:0] mode_ff;
   reg src_net_ff;
   reg [2:0] in_type_ff;
   reg bias_up_ff;
   reg [15:0] err_max_ff;
   reg [15:0] err_min_ff;
   reg [15:0] ot_ff;
   reg [15:0] sw_pt_ff;
   reg [15:0] per_min_ff;
   reg [15:0] curve_x [0:6];
   reg [15:0] curve_y [0:6];
   reg [15:0] prof [0:5];
   reg [15:0] step_tm [0:5];
   reg [15:0] step_ia [0:5];
   reg [15:0] step_ib [0:5];
   reg [6:0] state_ff;
   reg [31:0] cyc_ff;
   reg [15:0] sec_ff;
   reg [31:0] per_cyc_ff;
   reg [15:0] per_sec_ff;
   reg armed_ff;
   reg fault_ff;
   reg [15:0] temp_ff;
   reg [6:0] nxt_state;
   integer i;

   // piecewise linear interpolation on a segment
   function [15:0] lerp;
      input [15:0] x, x0, x1, y0, y1;
      reg [31:0] d;
      begin
         if (x1 <= x0) begin
            lerp = y1;
         end else begin
            d = (x - x0) * (y1 > y0 ? y1 - y0 : y0 - y1) / (x1 - x0);
            lerp = y1 > y0 ? y0 + d[15:0] : y0 - d[15:0];
         end
      end
   endfunction

   // seven-point conversion to degrees
   reg [15:0] conv_t;
   always @* begin
      conv_t = curve_y[6];
      if (ext_raw_in <= curve_x[0]) begin
         conv_t = curve_y[0];
      end
      for (i = 5; i >= 0; i = i - 1) begin
         if (ext_raw_in > curve_x[i] && ext_raw_in <= curve_x[i+1]) begin
            conv_t = lerp(ext_raw_in, curve_x[i], curve_x[i+1],
                          curve_y[i], curve_y[i+1]);
         end
      end
      if (in_type_ff == `FRS_IN_TSENS) begin
         conv_t = ext_raw_in;
      end
   end

   // six-point profile: deadbands give zero
   wire [15:0] ctl_in = src_net_ff ? net_value_in : temp_ff;
   reg [15:0] prof_a;
   always @* begin
      prof_a = 16'h0000;
      if (ctl_in >= prof[0] && ctl_in <= prof[5]) begin
         if (ctl_in < prof[1]) begin
            prof_a = 16'h0000;
         end else if (ctl_in < prof[2]) begin
            prof_a = lerp(ctl_in, prof[1], prof[2], 16'h0000, 16'h0200);
         end else if (ctl_in < prof[3]) begin
            prof_a = lerp(ctl_in, prof[2], prof[3], 16'h0200, 16'h0500);
         end else if (ctl_in < prof[4]) begin
            prof_a = lerp(ctl_in, prof[3], prof[4], 16'h0500, 16'h07d0);
         end else begin
            prof_a = 16'h07d0;
         end
      end
   end

   // fault limits
   wire hi_err = (err_max_ff != `FRS_FULL_SCALE) && (ext_raw_in > err_max_ff);
   wire lo_err = (err_min_ff != 16'h0000) && (ext_raw_in < err_min_ff);
   wire hot = temp_ff > ot_ff;
   wire net_hi = net_value_in > sw_pt_ff;
   wire [31:0] per_lim = {16'h0000, per_min_ff};
   wire per_due = (per_min_ff != 16'h0000) &&
                  ({16'h0000, per_sec_ff} >= per_lim);

   reg trig;
   always @* begin
      case (mode_ff)
         `FRS_MODE_OTC: trig = hot;
         `FRS_MODE_OTO: trig = hot && armed_ff;
         `FRS_MODE_NET: trig = net_hi;
         `FRS_MODE_PER: trig = per_due;
         default: trig = 1'b0;
      endcase
   end

   wire sec_tick = (cyc_ff == SEC_CYC - 1);
   wire [15:0] cur_tm = state_ff == ST_STOPF ? step_tm[0] :
                        state_ff == ST_BOOST ? 16'h0001 :
                        state_ff == ST_REV ? step_tm[2] :
                        state_ff == ST_STOPR ? step_tm[3] :
                        state_ff == ST_BURST ? step_tm[4] : step_tm[5];
   wire step_done = sec_tick && (sec_ff + 16'h0001 >= cur_tm);

   // sequence steps in order
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (trig && !fault_ff) nxt_state = ST_STOPF;
         ST_STOPF: if (step_done) nxt_state = ST_BOOST;
         ST_BOOST: if (step_done) nxt_state = ST_REV;
         ST_REV: if (step_done && !(mode_ff == `FRS_MODE_OTC && hot))
            nxt_state = ST_STOPR;
         ST_STOPR: if (step_done || step_tm[3] == 16'h0000)
            nxt_state = step_tm[4] == 16'h0000 ? ST_LOCK : ST_BURST;
         ST_BURST: if (step_done) nxt_state = ST_LOCK;
         ST_LOCK: if (step_done || step_tm[5] == 16'h0000)
            nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   wire [2:0] sidx = state_ff == ST_BOOST ? 3'h1 : state_ff == ST_REV ? 3'h2 :
                     state_ff == ST_STOPR ? 3'h3 : state_ff == ST_BURST ? 3'h4 :
                     state_ff == ST_LOCK ? 3'h5 : 3'h0;

   always @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         mode_ff <= `FRS_MODE_OFF;
         src_net_ff <= 1'b0;
         in_type_ff <= 3'h0;
         bias_up_ff <= 1'b0;
         err_max_ff <= `FRS_FULL_SCALE;
         err_min_ff <= 16'h0000;
         ot_ff <= `FRS_OT_DEFAULT;
         sw_pt_ff <= 16'h0000;
         per_min_ff <= `FRS_PER_DEFAULT;
         for (i = 0; i < 7; i = i + 1) begin
            curve_x[i] <= 16'h0000;
            curve_y[i] <= 16'h0000;
         end
         for (i = 0; i < 6; i = i + 1) begin
            prof[i] <= 16'h0000;
            step_tm[i] <= 16'h0000;
            step_ia[i] <= 16'h0000;
            step_ib[i] <= 16'h0000;
         end
         state_ff <= ST_IDLE;
         cyc_ff <= 32'h0;
         sec_ff <= 16'h0000;
         per_cyc_ff <= 32'h0;
         per_sec_ff <= 16'h0000;
         armed_ff <= 1'b1;
         fault_ff <= 1'b0;
         temp_ff <= 16'h0000;
         reg_rdata_out <= 32'h0;
         coil_a_ma_out <= 16'h0000;
         coil_b_ma_out <= 16'h0000;
         bias_pullup_out <= 1'b0;
         bias_pulldown_out <= 1'b0;
         err_msg_out <= 1'b0;
         fault_out <= 1'b0;
         seq_active_out <= 1'b0;
      end else begin
         if (reg_wr_in) begin
            case (reg_addr_in)
               `FRS_A_CTRL: begin
                  mode_ff <= reg_wdata_in[2:0];
                  src_net_ff <= reg_wdata_in[4];
               end
               `FRS_A_INCFG: begin
                  in_type_ff <= reg_wdata_in[2:0];
                  bias_up_ff <= reg_wdata_in[4];
               end
               `FRS_A_ERRLIM: begin
                  err_max_ff <= reg_wdata_in[31:16];
                  err_min_ff <= reg_wdata_in[15:0];
               end
               `FRS_A_TEMPPT: begin
                  curve_x[reg_wdata_in[2:0]] <= reg_wdata_in[31:16];
                  curve_y[reg_wdata_in[2:0]] <= reg_wdata_in[15:0];
               end
               `FRS_A_PROF: prof[reg_wdata_in[2:0]] <= reg_wdata_in[31:16];
               `FRS_A_STEPTM: step_tm[reg_wdata_in[2:0]] <= reg_wdata_in[31:16];
               `FRS_A_STEPI: begin
                  step_ia[reg_wdata_in[2:0]] <= {4'h0, reg_wdata_in[31:20]};
                  step_ib[reg_wdata_in[2:0]] <= {4'h0, reg_wdata_in[19:8]};
               end
               `FRS_A_TRIG: begin
                  ot_ff <= reg_wdata_in[15:0];
                  sw_pt_ff <= reg_wdata_in[31:16];
               end
               `FRS_A_OUT: per_min_ff <= reg_wdata_in[15:0];
               default: ;
            endcase
         end
         reg_rdata_out <= 32'h0;
         if (reg_rd_in) begin
            case (reg_addr_in)
               `FRS_A_CTRL: reg_rdata_out <= {27'h0, src_net_ff, 1'b0, mode_ff};
               `FRS_A_INCFG: reg_rdata_out <= {27'h0, bias_up_ff, 1'b0,
                                               in_type_ff};
               `FRS_A_ERRLIM: reg_rdata_out <= {err_max_ff, err_min_ff};
               `FRS_A_TRIG: reg_rdata_out <= {sw_pt_ff, ot_ff};
               `FRS_A_STAT: reg_rdata_out <= {temp_ff, 7'h0, state_ff,
                                              armed_ff, fault_ff};
               `FRS_A_OUT: reg_rdata_out <= {16'h0000, per_min_ff};
               default: reg_rdata_out <= 32'h0;
            endcase
         end
         temp_ff <= conv_t;
         fault_ff <= hi_err || lo_err;
         err_msg_out <= (hi_err || lo_err) && !fault_ff;
         fault_out <= hi_err || lo_err;
         bias_pullup_out <= (in_type_ff == 3'h5 || in_type_ff == 3'h6) &&
                            bias_up_ff;
         bias_pulldown_out <= (in_type_ff == 3'h5 || in_type_ff == 3'h6) &&
                              !bias_up_ff;
         if (!hot) begin
            armed_ff <= 1'b1;
         end else if (state_ff == ST_IDLE && nxt_state == ST_STOPF) begin
            armed_ff <= 1'b0;
         end
         state_ff <= nxt_state;
         if (nxt_state != state_ff || state_ff == ST_IDLE) begin
            cyc_ff <= 32'h0;
            sec_ff <= 16'h0000;
         end else if (sec_tick) begin
            cyc_ff <= 32'h0;
            sec_ff <= sec_ff + 16'h0001;
         end else begin
            cyc_ff <= cyc_ff + 32'h1;
         end
         // period counts minutes in idle only
         if (state_ff != ST_IDLE || nxt_state != ST_IDLE) begin
            per_cyc_ff <= 32'h0;
            per_sec_ff <= 16'h0000;
         end else if (per_cyc_ff == SEC_CYC * `FRS_MIN_SEC - 1) begin
            per_cyc_ff <= 32'h0;
            per_sec_ff <= per_sec_ff + 16'h0001;
         end else begin
            per_cyc_ff <= per_cyc_ff + 32'h1;
         end
         seq_active_out <= nxt_state != ST_IDLE;
         if (fault_ff) begin
            coil_a_ma_out <= 16'h0000;
            coil_b_ma_out <= 16'h0000;
         end else if (state_ff == ST_IDLE) begin
            coil_a_ma_out <= prof_a;
            coil_b_ma_out <= 16'h0000;
         end else begin
            coil_a_ma_out <= step_ia[sidx];
            coil_b_ma_out <= state_ff == ST_BURST ? 16'h0000 :
                             step_ib[sidx];
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/frs_far_model.sv
// far side model: sensor value and network message value
`timescale 1ns/10ps
`default_nettype none
module frs_far_model (
   input wire logic clk_in,
   input wire logic [15:0] temp_in,
   input wire logic [15:0] net_in,
   output logic [15:0] ext_raw_out,
   output logic [15:0] net_value_out
);
   initial begin
      ext_raw_out = 16'h0;
      net_value_out = 16'h0;
   end
   always @(posedge clk_in) begin
      ext_raw_out <= temp_in;
      net_value_out <= net_in;
   end
endmodule
`default_nettype wire

//--- tb/frs_top_props.sv
// assertions on the fan reverse sequencer ports
`timescale 1ns/10ps
`default_nettype none
module frs_top_props (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [15:0] coil_a_ma_out,
   input wire logic [15:0] coil_b_ma_out,
   input wire logic bias_pullup_out,
   input wire logic bias_pulldown_out,
   input wire logic err_msg_out,
   input wire logic fault_out,
   input wire logic seq_active_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   a_coil_b_idle: assert property (
      (!seq_active_out)[*4] |-> coil_b_ma_out == 16'h0)
      else $error("coil b driven while idle");
   a_fault_standby: assert property (
      fault_out[*3] |-> coil_a_ma_out == 16'h0 && coil_b_ma_out == 16'h0)
      else $error("coils not standby in fault");
   a_err_pulse: assert property (
      err_msg_out |=> !err_msg_out)
      else $error("error message not a pulse");
   a_err_onset: assert property (
      $rose(fault_out) |-> err_msg_out || $past(err_msg_out))
      else $error("no error message at fault onset");
   a_err_cause: assert property (
      err_msg_out |-> ##[0:1] fault_out)
      else $error("error message without fault");
   a_rdata_idle: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data outside read slot");
   a_bias_excl: assert property (
      !(bias_pullup_out && bias_pulldown_out))
      else $error("both bias outputs on");
   a_seq_runs: assert property (
      $rose(seq_active_out) |-> seq_active_out[*8])
      else $error("sequence cut short");
   a_no_start_flt: assert property (
      fault_out[*3] |-> !$rose(seq_active_out))
      else $error("sequence started in fault");
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the fan reverse sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [3:0] reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [15:0] t_cmd = 16'h0;
   logic [15:0] n_cmd = 16'h0;
   wire [31:0] reg_rdata_out;
   wire [15:0] ext_raw_in, net_value_in, coil_a_ma_out, coil_b_ma_out;
   wire bias_pullup_out, bias_pulldown_out, err_msg_out, fault_out;
   wire seq_active_out;
   int miscompares = 0;
   int checked = 0;
   int n_err = 0;
   int ne, n, i, v;
   int tv[6] = '{10, 49, 50, 300, 301, 100};
   logic pf, f;
   logic [31:0] d;
   always #25 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) if (err_msg_out === 1'b1) n_err++;
   frs_top #(.SEC_CYC(10)) u_dut (.clk_sys_in, .sys_rst_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ext_raw_in,
      .net_value_in, .coil_a_ma_out, .coil_b_ma_out, .bias_pullup_out,
      .bias_pulldown_out, .err_msg_out, .fault_out, .seq_active_out);
   frs_far_model u_far (.clk_in(clk_sys_in), .temp_in(t_cmd),
      .net_in(n_cmd), .ext_raw_out(ext_raw_in), .net_value_out(net_value_in));
   task end_sim;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk_sys_in);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] w);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= w;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] r);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1;
      r = reg_rdata_out;
   endtask
   task settemp(input logic [15:0] t);
      @(posedge clk_sys_in);
      t_cmd <= t;
      cyc(5);
   endtask
   // waits for sequence level v, counts cycles
   task wseq(input logic v, input int lim, output int k);
      k = 0;
      while (seq_active_out !== v) begin
         cyc(1);
         k++;
         if (k > lim) begin
            miscompares++;
            $display("ERROR %0t: wait timeout", $time);
            end_sim;
         end
      end
   endtask
   initial begin
      void'($urandom(32'ha63bda80));
      repeat (16) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      rd(4'h9, d);
      chk(d, 32'd1800);
      rd(4'h7, d);
      chk(d, 32'd145);
      wr(4'h1, 32'h4);
      settemp(16'd200);
      rd(4'hf, d);
      chk(d, 32'h0);
      rd(4'h8, d);
      chk(d[31:16], 32'd200);
      cyc(100);
      chk(seq_active_out, 1'b0);
      chk(coil_b_ma_out, 16'h0);
      $display("test disabled done");
      for (i = 0; i < 7; i++) begin
         wr(4'h1, 32'h10 | i);
         cyc(3);
         chk(bias_pullup_out, i >= 5);
         chk(bias_pulldown_out, 1'b0);
      end
      wr(4'h1, 32'h6);
      cyc(3);
      chk(bias_pulldown_out, 1'b1);
      wr(4'h1, 32'h4);
      $display("test bias done");
      wr(4'h2, {16'd300, 16'd50});
      ne = 0;
      pf = 1'b0;
      for (i = 0; i < 10; i++) begin
         v = (i < 6) ? tv[i] : $urandom_range(400);
         settemp(v[15:0]);
         f = (v > 300) || (v < 50);
         if (f && !pf) ne++;
         pf = f;
         chk(fault_out, f);
      end
      chk(n_err, ne);
      wr(4'h2, {16'hffff, 16'h0});
      settemp(16'h0);
      chk(fault_out, 1'b0);
      settemp(16'hffff);
      chk(fault_out, 1'b0);
      settemp(16'd145);
      $display("test fault done");
      for (i = 0; i < 6; i++) begin
         wr(4'h4, {i[15:0] * 16'd100, 13'h0, i[2:0]});
      end
      wr(4'h0, 32'h10);
      @(posedge clk_sys_in);
      n_cmd <= 16'd150;
      cyc(5);
      chk(coil_a_ma_out, 32'd256);
      @(posedge clk_sys_in);
      n_cmd <= 16'd450;
      cyc(5);
      chk(coil_a_ma_out, 32'd2000);
      @(posedge clk_sys_in);
      n_cmd <= 16'd600;
      cyc(5);
      chk(coil_a_ma_out, 32'd0);
      $display("test profile done");
      for (i = 0; i < 8; i++) begin
         wr(4'h5, {16'd1, 13'h0, i[2:0]});
         wr(4'h6, {12'd100, 12'd200, 5'h0, i[2:0]});
      end
      wr(4'h0, 32'h2);
      cyc(30);
      chk(seq_active_out, 1'b0);
      settemp(16'd146);
      wseq(1'b1, 20, n);
      cyc(15);
      chk(coil_a_ma_out, 16'd100);
      chk(coil_b_ma_out, 16'd200);
      wseq(1'b0, 3000, n);
      chk(n >= 40 && n <= 50, 1'b1);
      cyc(100);
      chk(seq_active_out, 1'b0);
      settemp(16'd100);
      settemp(16'd150);
      wseq(1'b1, 20, n);
      wseq(1'b0, 3000, n);
      $display("test once done");
      settemp(16'd100);
      wr(4'h7, {16'd100, 16'd145});
      @(posedge clk_sys_in);
      n_cmd <= 16'd200;
      wr(4'h0, 32'h3);
      wseq(1'b1, 20, n);
      wseq(1'b0, 3000, n);
      wseq(1'b1, 20, n);
      @(posedge clk_sys_in);
      n_cmd <= 16'd50;
      wseq(1'b0, 3000, n);
      cyc(100);
      chk(seq_active_out, 1'b0);
      $display("test network done");
      wr(4'h0, 32'h1);
      settemp(16'd150);
      wseq(1'b1, 20, n);
      cyc(200);
      chk(seq_active_out, 1'b1);
      settemp(16'd100);
      wseq(1'b0, 100, n);
      chk(n <= 40, 1'b1);
      $display("test continuous done");
      wr(4'h9, 32'h1);
      wr(4'h0, 32'h4);
      wseq(1'b1, 2000, n);
      wseq(1'b0, 3000, n);
      wseq(1'b1, 2000, n);
      chk(n >= 597 && n <= 603, 1'b1);
      $display("test periodic done");
      end_sim;
   end
endmodule
bind frs_top frs_top_props u_props (.clk_sys_in, .sys_rst_in, .reg_rd_in,
   .reg_rdata_out, .coil_a_ma_out, .coil_b_ma_out, .bias_pullup_out,
   .bias_pulldown_out, .err_msg_out, .fault_out, .seq_active_out);
`default_nettype wire
